// ===== src/acd_pkg.sv
// Purpose: shared constants and types of the angle conditioning datapath
// Assumes: codes are 13-bit fractions of supply, angles are 16-bit turns of 180 deg mechanical
// Notes: angle unit is 65536 per 180 deg mechanical (360 deg electrical)
package acd_pkg;
	localparam int SAMPLE_W = 14;
	localparam int CODE_W = 13;
	localparam int ANG_W = 16;
	localparam int VEC_W = 18;
	localparam int CORDIC_ITER = 14;
	localparam int DIV_STEPS = 29;
	localparam int TRIM_W = 28;
	localparam int DECIM_LEN_DEF = 16384;
	localparam logic [13:0] SAMPLE_MAX = 14'h3FFF;
	localparam logic [13:0] SAMPLE_MID = 14'h2000;
	localparam logic [12:0] CODE_VALID_LO = 13'h019A;
	localparam logic [12:0] CODE_VALID_HI = 13'h1E66;
	localparam logic [12:0] CODE_SPAN = 13'h1CCC;
	localparam logic [12:0] CODE_CLAMP_LO = 13'h01C2;
	localparam logic [12:0] CODE_CLAMP_HI = 13'h1E8F;
	localparam logic [12:0] CODE_DIAG_LO = 13'h007B;
	localparam logic [15:0] ANG_HALF = 16'h8000;
	localparam logic [15:0] ANG_ZP_STEP = 16'h00B6;
	localparam logic [4:0] ZP_CENTER = 5'h0A;
	localparam logic [4:0] ZP_STEPS = 5'h15;
	localparam logic [16:0] ANG_RANGE_STEP = 17'h0_0E39;
	localparam logic [16:0] ANG_FULL = 17'h1_0000;
	localparam logic [3:0] RANGE_MIN_STEPS = 4'h3;
	localparam logic [3:0] RANGE_FULL_IDX = 4'hF;
	localparam logic [17:0] MAG_MIN = 18'h0_0320;
	localparam logic [27:0] TRIM_RESET = 28'h000_0000;
	typedef enum logic [2:0] {ST_CFG, ST_DIV, ST_WAIT, ST_ROT, ST_MAP, ST_PUSH} acd_state_t;
endpackage

// ===== src/acd_datapath.sv
// Purpose: angle conditioning datapath, bitstreams in, 13-bit ratiometric code out
// Assumes: single free-running clock, modulator bitstreams and trim pins are asynchronous
// Notes: one top module; decimation, arctangent, mapping, trim and output buffer
// Overview of operation
// - each sensor bitstream is decimated by its own filter into a 14-bit sample
// - angle comes from an iterative shift-and-add arctangent, no multipliers
// - angle spans 180 deg mechanical whatever the range, independent of amplitude
// - range and zero point are digitized once after reset and then held
// - result is a 13-bit code for a ratiometric converter
// - valid codes span 5 to 95 percent; the 1 percent band below stays unused
// - below range hold 5-6 percent, above range hold 95-96 percent
// - with the full 180 deg range the output never clamps flat
// - with a range under 180 deg the output jumps between clamp levels at mid-gap, repeating periodically
// - a lost magnet drives the output to a low diagnostic level
// - a serial trim port loads sensor offsets and exposes the raw angle
// - nothing depends on absolute time, so an imprecise RC clock suffices
`timescale 1ns/1ps
`default_nettype none
module acd_datapath #(
	parameter int DECIM_LEN = acd_pkg::DECIM_LEN_DEF
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic sine_channel_input_i,
	input wire logic cosine_channel_input_i,
	input wire logic zero_point_setting_i,
	input wire logic angle_range_setting_i,
	input wire logic trim_mode_i,
	input wire logic trim_clk_i,
	input wire logic trim_data_i,
	input wire logic dac_ready_i,
	output logic [acd_pkg::CODE_W-1:0] ratiometric_angle_output_o,
	output logic dac_valid_o
);
	import acd_pkg::*;
	// window counts are scaled up to full 14-bit samples; window length must be a power of two
	localparam int DECIM_SH = SAMPLE_W - $clog2(DECIM_LEN);

	// saturating sample from a ones count of one window
	function automatic logic [13:0] sat_sample(input logic [14:0] ones);
		sat_sample = ones[14] ? SAMPLE_MAX : ones[13:0];
	endfunction

	// atan(2^-i) in angle units of the electrical turn
	function automatic logic [15:0] atan_lut(input logic [4:0] i);
		case (i)
			5'd0: atan_lut = 16'h2000;
			5'd1: atan_lut = 16'h12E4;
			5'd2: atan_lut = 16'h09FB;
			5'd3: atan_lut = 16'h0511;
			5'd4: atan_lut = 16'h028B;
			5'd5: atan_lut = 16'h0146;
			5'd6: atan_lut = 16'h00A3;
			5'd7: atan_lut = 16'h0051;
			5'd8: atan_lut = 16'h0029;
			5'd9: atan_lut = 16'h0014;
			5'd10: atan_lut = 16'h000A;
			5'd11: atan_lut = 16'h0005;
			5'd12: atan_lut = 16'h0003;
			default: atan_lut = 16'h0001;
		endcase
	endfunction

	// centred, offset-corrected channel value
	function automatic logic signed [17:0] centre(input logic [13:0] s, input logic [13:0] off);
		centre = $signed({4'h0, s}) - $signed({4'h0, SAMPLE_MID}) - $signed({{4{off[13]}}, off});
	endfunction

	// synchronisers: bit 0 sin, 1 cos, 2 zero point, 3 range, 4 trim mode, 5 trim clk, 6 trim data
	logic [6:0] pin_s1_reg;
	logic [6:0] pin_s2_reg;
	logic trim_clk_d_reg;
	logic trim_mode_d_reg;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_s1_reg <= 7'h00;
			pin_s2_reg <= 7'h00;
			trim_clk_d_reg <= 1'b0;
			trim_mode_d_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {trim_data_i, trim_clk_i, trim_mode_i, angle_range_setting_i,
				zero_point_setting_i, cosine_channel_input_i, sine_channel_input_i};
			pin_s2_reg <= pin_s1_reg;
			trim_clk_d_reg <= pin_s2_reg[5];
			trim_mode_d_reg <= pin_s2_reg[4];
		end
	end

	// decimation: all four bitstreams share one window counter
	logic [13:0] win_reg, win_next;
	logic [14:0] ones_reg [4];
	logic [14:0] ones_next [4];
	logic [13:0] samp_reg [4];
	logic [13:0] samp_next [4];
	logic stb_reg, stb_next;
	always_comb begin
		win_next = win_reg + 14'h0001;
		stb_next = 1'b0;
		for (int c = 0; c < 4; c++) begin
			ones_next[c] = ones_reg[c] + {14'h0000, pin_s2_reg[c]};
			samp_next[c] = samp_reg[c];
		end
		if (win_reg == 14'(DECIM_LEN - 1)) begin
			win_next = 14'h0000;
			stb_next = 1'b1;
			for (int c = 0; c < 4; c++) begin
				samp_next[c] = sat_sample(15'(ones_next[c] << DECIM_SH));
				ones_next[c] = 15'h0000;
			end
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			win_reg <= 14'h0000;
			stb_reg <= 1'b0;
			for (int c = 0; c < 4; c++) begin
				ones_reg[c] <= 15'h0000;
				samp_reg[c] <= 14'h0000;
			end
		end else begin
			win_reg <= win_next;
			stb_reg <= stb_next;
			for (int c = 0; c < 4; c++) begin
				ones_reg[c] <= ones_next[c];
				samp_reg[c] <= samp_next[c];
			end
		end
	end

	// trim port: shift on trim clock rising edges, offsets taken when trim mode ends
	logic [27:0] tshift_reg, tshift_next;
	logic [27:0] toff_reg, toff_next;
	always_comb begin
		tshift_next = tshift_reg;
		toff_next = toff_reg;
		if (pin_s2_reg[4] && pin_s2_reg[5] && !trim_clk_d_reg) begin
			tshift_next = {tshift_reg[26:0], pin_s2_reg[6]};
		end
		if (trim_mode_d_reg && !pin_s2_reg[4]) begin
			toff_next = tshift_reg;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tshift_reg <= TRIM_RESET;
			toff_reg <= TRIM_RESET;
		end else begin
			tshift_reg <= tshift_next;
			toff_reg <= toff_next;
		end
	end

	// main sequencer
	acd_state_t st_reg, st_next;
	logic [4:0] cnt_reg, cnt_next;
	logic signed [17:0] x_reg, x_next, y_reg, y_next;
	logic [15:0] z_reg, z_next;
	logic [15:0] zp_reg, zp_next;
	logic [16:0] range_reg, range_next;
	logic [16:0] rem_reg, rem_next;
	logic [28:0] quo_reg, quo_next;
	logic [12:0] code_reg, code_next;
	logic buf_in_ready;
	logic [4:0] zp_idx;
	logic [17:0] rem_try;
	logic [15:0] rel;
	logic [15:0] excess;
	logic [15:0] gap_half;
	logic [32:0] prod;
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		x_next = x_reg;
		y_next = y_reg;
		z_next = z_reg;
		zp_next = zp_reg;
		range_next = range_reg;
		rem_next = rem_reg;
		quo_next = quo_reg;
		code_next = code_reg;
		zp_idx = 5'((19'(samp_reg[2]) * 19'(ZP_STEPS)) >> 14);
		rem_try = {rem_reg, quo_reg[28]} - {1'b0, range_reg};
		rel = z_reg - zp_reg;
		excess = 16'(17'(rel) - range_reg);
		gap_half = 16'((ANG_FULL - range_reg) >> 1);
		prod = 33'(rel) * 33'(quo_reg[16:0]);
		case (st_reg)
			ST_CFG: begin
				if (stb_reg) begin
					zp_next = 16'((zp_idx - ZP_CENTER) * ANG_ZP_STEP);
					range_next = (samp_reg[3][13:10] == RANGE_FULL_IDX) ? ANG_FULL :
						(17'(samp_reg[3][13:10]) + 17'(RANGE_MIN_STEPS)) * ANG_RANGE_STEP;
					quo_next = {CODE_SPAN, 16'h0000};
					rem_next = 17'h0_0000;
					cnt_next = 5'd0;
					st_next = ST_DIV;
				end
			end
			ST_DIV: begin
				// gain = span / range in 13.16, computed once so the loop needs no divider
				if (!rem_try[17]) begin
					rem_next = rem_try[16:0];
					quo_next = {quo_reg[27:0], 1'b1};
				end else begin
					rem_next = {rem_reg[15:0], quo_reg[28]};
					quo_next = {quo_reg[27:0], 1'b0};
				end
				cnt_next = cnt_reg + 5'd1;
				if (cnt_reg == 5'(DIV_STEPS - 1)) begin
					st_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// samples arriving while busy are dropped; the next one is fresher anyway
				if (stb_reg) begin
					x_next = centre(samp_reg[1], toff_reg[13:0]);
					y_next = centre(samp_reg[0], toff_reg[27:14]);
					z_next = 16'h0000;
					if (centre(samp_reg[1], toff_reg[13:0]) < 0) begin
						x_next = -centre(samp_reg[1], toff_reg[13:0]);
						y_next = -centre(samp_reg[0], toff_reg[27:14]);
						z_next = ANG_HALF;
					end
					cnt_next = 5'd0;
					st_next = ST_ROT;
				end
			end
			ST_ROT: begin
				if (y_reg >= 0) begin
					x_next = x_reg + (y_reg >>> cnt_reg);
					y_next = y_reg - (x_reg >>> cnt_reg);
					z_next = z_reg + atan_lut(cnt_reg);
				end else begin
					x_next = x_reg - (y_reg >>> cnt_reg);
					y_next = y_reg + (x_reg >>> cnt_reg);
					z_next = z_reg - atan_lut(cnt_reg);
				end
				cnt_next = cnt_reg + 5'd1;
				if (cnt_reg == 5'(CORDIC_ITER - 1)) begin
					st_next = ST_MAP;
				end
			end
			ST_MAP: begin
				if ($unsigned(x_reg) < MAG_MIN) begin
					code_next = CODE_DIAG_LO;
				end else if (pin_s2_reg[4]) begin
					code_next = z_reg[15:3];
				end else if (17'(rel) < range_reg) begin
					code_next = CODE_VALID_LO + prod[28:16];
					if (prod[28:16] > CODE_SPAN) begin
						code_next = CODE_VALID_HI;
					end
				end else if (excess < gap_half) begin
					code_next = CODE_CLAMP_HI;
				end else begin
					code_next = CODE_CLAMP_LO;
				end
				st_next = ST_PUSH;
			end
			ST_PUSH: begin
				if (buf_in_ready) begin
					st_next = ST_WAIT;
				end
			end
			default: st_next = ST_CFG;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_reg <= ST_CFG;
			cnt_reg <= 5'd0;
			x_reg <= 18'sh0_0000;
			y_reg <= 18'sh0_0000;
			z_reg <= 16'h0000;
			zp_reg <= 16'h0000;
			range_reg <= ANG_FULL;
			rem_reg <= 17'h0_0000;
			quo_reg <= 29'h0000_0000;
			code_reg <= CODE_DIAG_LO;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			x_reg <= x_next;
			y_reg <= y_next;
			z_reg <= z_next;
			zp_reg <= zp_next;
			range_reg <= range_next;
			rem_reg <= rem_next;
			quo_reg <= quo_next;
			code_reg <= code_next;
		end
	end

	// two-entry output buffer; head slot drives the pins directly
	logic [12:0] d0_reg, d0_next, d1_reg, d1_next;
	logic v0_reg, v0_next, v1_reg, v1_next;
	logic push;
	assign buf_in_ready = !v1_reg;
	assign push = (st_reg == ST_PUSH) && buf_in_ready;
	always_comb begin
		d0_next = d0_reg;
		d1_next = d1_reg;
		v0_next = v0_reg;
		v1_next = v1_reg;
		if (v0_reg && dac_ready_i) begin
			d0_next = d1_reg;
			v0_next = v1_reg;
			v1_next = 1'b0;
		end
		if (push) begin
			if (!v0_next) begin
				d0_next = code_reg;
				v0_next = 1'b1;
			end else begin
				d1_next = code_reg;
				v1_next = 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			d0_reg <= CODE_DIAG_LO;
			d1_reg <= CODE_DIAG_LO;
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
		end else begin
			d0_reg <= d0_next;
			d1_reg <= d1_next;
			v0_reg <= v0_next;
			v1_reg <= v1_next;
		end
	end
	assign ratiometric_angle_output_o = d0_reg;
	assign dac_valid_o = v0_reg;
endmodule
`default_nettype wire

// ===== tb/acd_sensor_model.sv
// Purpose: first-order modulators standing in for the bridge pair and control unit
// Assumes: levels are 14-bit densities, 8192 = half scale
// Notes: streams run free, never idle
`timescale 1ns/1ps
`default_nettype none
module acd_sensor_model (
	input wire logic clk_i,
	input wire logic [3:0][13:0] level_i,
	output logic [3:0] bit_o
);
	logic [3:0][14:0] acc_reg = '0;
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			acc_reg[i] <= {1'b0, acc_reg[i][13:0]} + {1'b0, level_i[i]};
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			bit_o[i] = acc_reg[i][14];
		end
	end
endmodule
`default_nettype wire

// ===== tb/acd_checker_properties.sv
// Purpose: port checks of the datapath
// Assumes: one clock, synchronous active-high reset
// Notes: code limits pause after trim, raw angle shows then
`timescale 1ns/1ps
`default_nettype none
module acd_checker import acd_pkg::*; #(
	parameter int DECIM_LEN = 256
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic trim_mode_i,
	input wire logic dac_ready_i,
	input wire logic [acd_pkg::CODE_W-1:0] ratiometric_angle_output_o,
	input wire logic dac_valid_o
);
	logic [15:0] rst_cnt_reg, rst_cnt_next, trim_cnt_reg, trim_cnt_next;
	logic quiet;
	always_comb begin
		rst_cnt_next = (&rst_cnt_reg) ? rst_cnt_reg : rst_cnt_reg + 16'h0001;
		trim_cnt_next = (&trim_cnt_reg) ? trim_cnt_reg : trim_cnt_reg + 16'h0001;
		if (trim_mode_i || rst_i) begin
			trim_cnt_next = 16'h0000;
		end
		if (rst_i) begin
			rst_cnt_next = 16'h0000;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		rst_cnt_reg <= rst_cnt_next;
		trim_cnt_reg <= trim_cnt_next;
	end
	assign quiet = trim_cnt_reg > 16'(4 * DECIM_LEN);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_reset_code; $fell(rst_i) |-> ratiometric_angle_output_o == CODE_DIAG_LO; endproperty
	a_reset_code: assert property (p_reset_code) else $error("code after reset");
	property p_reset_valid; $fell(rst_i) |-> !dac_valid_o; endproperty
	a_reset_valid: assert property (p_reset_valid) else $error("valid after reset");
	property p_hold_code; dac_valid_o && !dac_ready_i |=> $stable(ratiometric_angle_output_o);
	endproperty
	a_hold_code: assert property (p_hold_code) else $error("code moved in stall");
	property p_hold_valid; dac_valid_o && !dac_ready_i |=> dac_valid_o; endproperty
	a_hold_valid: assert property (p_hold_valid) else $error("word lost in stall");
	property p_fall_taken; $fell(dac_valid_o) |-> $past(dac_ready_i); endproperty
	a_fall_taken: assert property (p_fall_taken) else $error("valid fell untaken");
	property p_floor; dac_valid_o && quiet |-> ratiometric_angle_output_o == CODE_DIAG_LO
		|| ratiometric_angle_output_o >= CODE_VALID_LO; endproperty
	a_floor: assert property (p_floor) else $error("code in low band");
	property p_ceiling; dac_valid_o && quiet |-> ratiometric_angle_output_o <= CODE_CLAMP_HI;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("code above clamp");
	property p_config_first; dac_valid_o |-> rst_cnt_reg > 16'(DECIM_LEN); endproperty
	a_config_first: assert property (p_config_first) else $error("word before config");
endmodule
bind acd_datapath acd_checker #(.DECIM_LEN(DECIM_LEN)) acd_checker_inst (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .trim_mode_i(trim_mode_i), .dac_ready_i(dac_ready_i),
	.ratiometric_angle_output_o(ratiometric_angle_output_o), .dac_valid_o(dac_valid_o));
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the datapath
// Assumes: short windows, full range and centred zero point at power-on
// Notes: words are queued as taken; stale ones dropped after a level change
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import acd_pkg::*;
	localparam int DL = 256;
	logic sys_clk_i = 0, rst_i = 1, trim_mode_i = 0, trim_clk_i = 0, trim_data_i = 0;
	logic dac_ready_i = 1;
	logic [3:0][13:0] lvl = {14'h3E80, SAMPLE_MID, SAMPLE_MID, SAMPLE_MID};
	logic [3:0] bits;
	logic [CODE_W-1:0] code, w1, w2, w3;
	logic valid;
	real ang_exp = 0.0;
	logic [CODE_W-1:0] words[$];
	int err_total = 0, tests_run = 0, cycles = 0;
	initial forever #10 sys_clk_i = ~sys_clk_i;
	acd_sensor_model acd_sensor_model_inst (.clk_i(sys_clk_i), .level_i(lvl), .bit_o(bits));
	acd_datapath #(.DECIM_LEN(DL)) acd_datapath_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.sine_channel_input_i(bits[0]), .cosine_channel_input_i(bits[1]),
		.zero_point_setting_i(bits[2]), .angle_range_setting_i(bits[3]),
		.trim_mode_i(trim_mode_i), .trim_clk_i(trim_clk_i), .trim_data_i(trim_data_i),
		.dac_ready_i(dac_ready_i), .ratiometric_angle_output_o(code), .dac_valid_o(valid));
	always @(posedge sys_clk_i) begin
		if (valid === 1'b1 && dac_ready_i === 1'b1 && !rst_i) words.push_back(code);
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			$display("unexpected at %0t: run hung", $time);
			end_sim();
		end
	end
	function automatic logic near(input logic [12:0] a, b, tol);
		return (a > b ? a - b : b - a) <= tol;
	endfunction
	// in-range code for an electrical angle in degrees and a range in angle units
	function automatic logic [12:0] exp_code(input real deg, input real rng_u);
		real z;
		z = deg / 360.0 * 65536.0;
		return 13'(int'(real'(CODE_VALID_LO) + z * real'(CODE_SPAN) / rng_u));
	endfunction
	task automatic chk_eq(input logic [CODE_W-1:0] got, exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %0d want %0d", $time, msg, got, exp);
		end
	endtask
	task automatic chk_true(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	// levels in steps of 128 give exact window counts, and halving an amplitude stays exact
	task automatic set_angle(input real deg, amp);
		int sv, cv;
		sv = 128 * int'(amp * $sin(deg * 3.14159265 / 90.0) / 128.0);
		cv = 128 * int'(amp * $cos(deg * 3.14159265 / 90.0) / 128.0);
		ang_exp = $atan2(real'(sv), real'(cv)) * 180.0 / 3.14159265;
		if (ang_exp < 0.0) begin
			ang_exp = ang_exp + 360.0;
		end
		@(posedge sys_clk_i);
		#2 lvl[0] = 14'(8192 + sv);
		lvl[1] = 14'(8192 + cv);
	endtask
	// the window under way at a change is mixed, so skip past it
	task automatic fresh_word(output logic [CODE_W-1:0] w);
		int n;
		repeat (2 * DL + 40) @(posedge sys_clk_i);
		words.delete();
		for (n = 0; n < 2 * DL && words.size() == 0; n++) @(posedge sys_clk_i);
		chk_true(words.size() > 0, "no word");
		w = (words.size() > 0) ? words.pop_front() : '0;
	endtask
	task automatic t_reset;
		repeat (5) @(posedge sys_clk_i);
		#2 chk_eq(code, CODE_DIAG_LO, "reset code");
		chk_true(valid === 1'b0, "reset valid");
		rst_i = 0;
		$display("test reset done");
	endtask
	task automatic t_diag;
		fresh_word(w1);
		chk_eq(w1, CODE_DIAG_LO, "magnet lost");
		$display("test diag done");
	endtask
	task automatic t_linear;
		set_angle(60.0, 5000.0);
		lvl[3] = 14'h0000;
		fresh_word(w1);
		chk_true(near(w1, exp_code(ang_exp, real'(ANG_FULL)), 13'h0008), "full range");
		set_angle(60.0, 2500.0);
		fresh_word(w2);
		set_angle(70.0, 5000.0);
		fresh_word(w3);
		chk_true(w1 >= CODE_VALID_LO && w1 <= CODE_VALID_HI, "valid span");
		chk_true(near(w1, w2, 13'h0008), "amplitude");
		chk_true(near(w3 - w1, 13'h019A, 13'h0014), "10 deg step");
		$display("test linear done");
	endtask
	task automatic t_stall;
		int n;
		@(posedge sys_clk_i);
		#2 dac_ready_i = 0;
		for (n = 0; n < 3 * DL && valid !== 1'b1; n++) @(posedge sys_clk_i);
		repeat (3 * DL) @(posedge sys_clk_i);
		#2 chk_true(valid === 1'b1, "stall valid");
		chk_eq(code, w3, "stall code");
		dac_ready_i = 1;
		$display("test stall done");
	endtask
	task automatic t_trim;
		logic [27:0] pat;
		pat = {14'h0280, 14'h0000};
		set_angle(60.0, 5000.0);
		trim_mode_i = 1;
		fresh_word(w2);
		chk_true(near(w2, 13'(int'(ang_exp / 360.0 * 8192.0)), 13'h0008), "raw angle");
		// the sine bridge now reads high; the trimmed offset must cancel it
		@(posedge sys_clk_i);
		#2 lvl[0] = lvl[0] + 14'h0280;
		for (int i = 27; i >= 0; i--) begin
			trim_data_i = pat[i];
			repeat (4) @(posedge sys_clk_i);
			#2 trim_clk_i = 1;
			repeat (4) @(posedge sys_clk_i);
			#2 trim_clk_i = 0;
		end
		trim_mode_i = 0;
		trim_data_i = 0;
		fresh_word(w2);
		chk_true(near(w1, w2, 13'h0008), "sine offset trimmed");
		$display("test trim done");
	endtask
	// a second reset takes a 60 deg range; then inside, above and past the basic range
	task automatic t_range;
		real rng;
		rng = real'(3 + int'(RANGE_MIN_STEPS)) * real'(ANG_RANGE_STEP);
		@(posedge sys_clk_i);
		#2 lvl[3] = 14'h0E00;
		rst_i = 1;
		t_reset();
		set_angle(30.0, 5000.0);
		fresh_word(w1);
		chk_true(near(w1, exp_code(ang_exp, rng), 13'h0008), "narrow range");
		set_angle(75.0, 5000.0);
		fresh_word(w2);
		chk_eq(w2, CODE_CLAMP_HI, "above range");
		set_angle(170.0, 5000.0);
		fresh_word(w3);
		chk_eq(w3, CODE_CLAMP_LO, "past basic range");
		$display("test range done");
	endtask
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		t_reset();
		t_diag();
		t_linear();
		t_stall();
		t_trim();
		t_range();
		end_sim();
	end
endmodule
`default_nettype wire
